// ---- hdl/fcg_pkg.sv ----
package fcg_pkg;

   localparam int CLK_MHZ = 40;
   localparam longint CLK_HZ = 40_000_000;

   // Clock mode field codes
   localparam logic [1:0] MODE_SCM = 2'h0;
   localparam logic [1:0] MODE_FEI = 2'h1;
   localparam logic [1:0] MODE_FBE = 2'h2;
   localparam logic [1:0] MODE_FEE = 2'h3;

   localparam logic [6:0] PRESCALE_LOW  = 7'h40;
   localparam logic [6:0] PRESCALE_HIGH = 7'h01;

   // Loop output range; the DCO level toggles at a quarter of the loop rate
   localparam longint DCO_MIN_HZ = 8_000_000;
   localparam longint DCO_MAX_HZ = 40_000_000;
   localparam logic [15:0] DCO_MIN_W =
      16'(DCO_MIN_HZ * 64'd16384 / CLK_HZ);
   localparam logic [15:0] DCO_MAX_W =
      16'(DCO_MAX_HZ * 64'd16384 / CLK_HZ);
   localparam logic [15:0] DCO_RESET_W = 16'h1000;
   // Filter word step per reference period, well inside the lock window
   localparam logic [15:0] DCO_STEP    = 16'h0100;

   localparam logic [15:0] LOCK_TOL     = 16'h0002;
   localparam logic [1:0]  LOCK_WINDOWS = 2'h3;

   // Internal reference: period = base + trim, about 243 kHz at mid trim
   localparam logic [8:0] INT_REF_BASE = 9'h024;
   localparam logic [7:0] TRIM_RESET   = 8'h80;

   // Debug local clock near 8 MHz: five cycles, three high
   localparam logic [2:0] DBG_PERIOD = 3'h5;
   localparam logic [2:0] DBG_HIGH   = 3'h3;

   localparam logic [15:0] RTI_HALF = 16'h4e20;

   localparam int REF_LOSS_NS = 100_000;
   localparam logic [11:0] REF_LOSS_CYC =
      12'(REF_LOSS_NS * CLK_MHZ / 1000);

   typedef enum logic [6:0] {
      S_OFF     = 7'h01,
      S_SCM     = 7'h02,
      S_FEI_UNL = 7'h04,
      S_FEI_LCK = 7'h08,
      S_FBE     = 7'h10,
      S_FEE_UNL = 7'h20,
      S_FEE_LCK = 7'h40
   } fcg_state_t;

   typedef struct packed {
      logic       high_gain_select;
      logic       range_high;
      logic       reference_type_select;
      logic [1:0] clock_mode_select;
   } fcg_cfg_t;

   typedef struct packed {
      logic       osc_enable;
      logic       high_gain_select;
      logic       range_high;
      logic       reference_type_select;
   } fcg_osc_t;

   typedef struct packed {
      logic       locked;
      logic       lost_lock;
      logic       ref_valid;
      logic       ext_blocked;
      fcg_state_t state;
   } fcg_status_t;

endpackage : fcg_pkg

// ---- hdl/fcg_clock_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module fcg_clock_gen
   import fcg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        cfg_write,
   input  wire fcg_cfg_t    cfg_data,
   input  wire logic [2:0]  mult_select,
   input  wire logic [2:0]  post_div_select,
   input  wire logic        trim_write,
   input  wire logic [7:0]  trim_data,
   input  wire logic        stop_request,
   input  wire logic        loss_select,
   input  wire logic        loss_clear,
   input  wire logic        ext_ref_pin,
   output logic             gen_clock_out,
   output logic             loop_multiplied_clock,
   output logic             external_reference_clock,
   output logic             debug_local_clock,
   output logic             rti_clock,
   output logic             fixed_freq_enable,
   output logic             loss_reset_req,
   output logic             loss_irq,
   output logic [7:0]       internal_ref_trim,
   output fcg_osc_t         osc_ctl,
   output fcg_status_t      status
);

   typedef struct packed {
      fcg_state_t  state;
      logic [1:0]  mode;
      logic        cfg_done;
      logic        ext_blocked;
      logic        high_gain;
      logic        range_high;
      logic        ref_osc;
      logic [7:0]  trim;
      logic [2:0]  mult;
      logic [2:0]  post_div;
      logic [2:0]  ref_sync;
      logic        ref_lvl;
      logic [11:0] ref_tmr;
      logic        ref_valid;
      logic [8:0]  int_cnt;
      logic [2:0]  dbg_cnt;
      logic [15:0] rti_cnt;
      logic [15:0] dco_w;
      logic [15:0] dco_acc;
      logic        dco_prev;
      logic [15:0] edge_cnt;
      logic [1:0]  good_cnt;
      logic        lost_lock;
      logic [6:0]  div_cnt;
      logic        src_prev;
      logic        gen_out;
      logic        dbg_out;
      logic        rti_out;
      logic        ffe;
      logic        loss_rst;
      logic        loss_irq;
      logic        osc_en;
      logic        locked;
   } fcg_reg_t;

   fcg_reg_t r_reg;
   fcg_reg_t r_next;

   logic        ext_rise;
   logic        int_tick;
   logic        ref_tick;
   logic        ext_eng;
   logic        ext_mode;
   logic        engaged;
   logic        is_locked;
   logic        dco_lvl;
   logic        dco_rise;
   logic        src_lvl;
   logic        lock_lost;
   logic        clk_lost;
   logic        allow_ext;
   logic [6:0]  prescale;
   logic [15:0] target;
   logic [15:0] sum_acc;
   logic [7:0]  div_taps;

   always_comb begin
      r_next = r_reg;

      // Write-once configuration and mode request
      allow_ext = !(r_reg.cfg_done && r_reg.ext_blocked);
      if (cfg_write) begin
         if (!r_reg.cfg_done) begin
            r_next.cfg_done    = 1'b1;
            r_next.high_gain   = cfg_data.high_gain_select;
            r_next.range_high  = cfg_data.range_high;
            r_next.ref_osc     = cfg_data.reference_type_select;
            r_next.ext_blocked = !cfg_data.clock_mode_select[1];
         end
         if (allow_ext || !cfg_data.clock_mode_select[1]) begin
            r_next.mode = cfg_data.clock_mode_select;
         end
      end
      if (trim_write) begin
         r_next.trim = trim_data;
      end
      r_next.mult     = mult_select;
      r_next.post_div = post_div_select;

      // External reference: three stages, change taken when two agree
      r_next.ref_sync = {r_reg.ref_sync[1:0], ext_ref_pin};
      ext_rise = 1'b0;
      if (r_reg.ref_sync[1] == r_reg.ref_sync[2]) begin
         r_next.ref_lvl = r_reg.ref_sync[2];
         ext_rise = r_reg.ref_sync[2] && !r_reg.ref_lvl;
      end
      if (ext_rise) begin
         r_next.ref_tmr   = 12'h000;
         r_next.ref_valid = 1'b1;
      end else if (r_reg.ref_tmr == REF_LOSS_CYC) begin
         r_next.ref_valid = 1'b0;
      end else begin
         r_next.ref_tmr = r_reg.ref_tmr + 12'h001;
      end

      // Trimmable internal reference
      int_tick = (r_reg.int_cnt >= INT_REF_BASE + {1'b0, r_reg.trim});
      if (int_tick) begin
         r_next.int_cnt = 9'h001;
      end else begin
         r_next.int_cnt = r_reg.int_cnt + 9'h001;
      end

      // Debug local clock and separate real-time interrupt source
      if (r_reg.dbg_cnt == DBG_PERIOD - 3'h1) begin
         r_next.dbg_cnt = 3'h0;
      end else begin
         r_next.dbg_cnt = r_reg.dbg_cnt + 3'h1;
      end
      r_next.dbg_out = (r_reg.dbg_cnt < DBG_HIGH);
      if (r_reg.rti_cnt == RTI_HALF - 16'h0001) begin
         r_next.rti_cnt = 16'h0000;
         r_next.rti_out = !r_reg.rti_out;
      end else begin
         r_next.rti_cnt = r_reg.rti_cnt + 16'h0001;
      end

      // Digitally controlled oscillator, frozen in off mode
      dco_lvl  = r_reg.dco_acc[15];
      dco_rise = dco_lvl && !r_reg.dco_prev;
      sum_acc  = r_reg.dco_acc + r_reg.dco_w;
      if (r_reg.state != S_OFF) begin
         r_next.dco_acc  = sum_acc;
         r_next.dco_prev = dco_lvl;
      end

      ext_eng   = (r_reg.state == S_FEE_UNL) ||
                  (r_reg.state == S_FEE_LCK);
      ext_mode  = ext_eng || (r_reg.state == S_FBE);
      engaged   = ext_eng || (r_reg.state == S_FEI_UNL) ||
                  (r_reg.state == S_FEI_LCK);
      is_locked = (r_reg.state == S_FEI_LCK) ||
                  (r_reg.state == S_FEE_LCK);
      ref_tick  = ext_eng ? ext_rise : int_tick;

      if (ext_eng && !r_reg.range_high) begin
         prescale = PRESCALE_LOW;
      end else if (ext_eng) begin
         prescale = PRESCALE_HIGH;
      end else begin
         prescale = PRESCALE_LOW;
      end
      target = 16'(({13'h0000, r_reg.mult} + 16'h0001) *
                   {9'h000, prescale});

      // Frequency-locked loop: compare DCO edges per reference period
      lock_lost = 1'b0;
      if (!engaged) begin
         r_next.edge_cnt = 16'h0000;
         r_next.good_cnt = 2'h0;
      end else if (ref_tick) begin
         r_next.edge_cnt = 16'h0000;
         if (r_reg.edge_cnt + LOCK_TOL < target) begin
            r_next.good_cnt = 2'h0;
            lock_lost = is_locked;
            r_next.dco_w = (r_reg.dco_w > DCO_MAX_W - DCO_STEP) ?
                           DCO_MAX_W : r_reg.dco_w + DCO_STEP;
         end else if (r_reg.edge_cnt > target + LOCK_TOL) begin
            r_next.good_cnt = 2'h0;
            lock_lost = is_locked;
            r_next.dco_w = (r_reg.dco_w < DCO_MIN_W + DCO_STEP) ?
                           DCO_MIN_W : r_reg.dco_w - DCO_STEP;
         end else if (r_reg.good_cnt != LOCK_WINDOWS) begin
            r_next.good_cnt = r_reg.good_cnt + 2'h1;
         end
      end else if (dco_rise) begin
         r_next.edge_cnt = r_reg.edge_cnt + 16'h0001;
      end
      // Without reference ticks the filter word is left alone

      clk_lost = ext_mode && r_reg.ref_valid && !r_next.ref_valid;

      // Mode state machine
      unique case (r_reg.state)
         S_OFF: begin
            if (!stop_request) begin
               r_next.state = S_SCM;
            end
         end
         S_SCM, S_FBE, S_FEI_UNL, S_FEI_LCK,
         S_FEE_UNL, S_FEE_LCK: begin
            unique case (r_reg.mode)
               MODE_SCM: r_next.state = S_SCM;
               MODE_FEI: begin
                  if (r_reg.state != S_FEI_LCK) begin
                     r_next.state = S_FEI_UNL;
                  end
               end
               MODE_FBE: begin
                  r_next.state = r_reg.ref_valid ?
                                 S_FBE : S_SCM;
               end
               MODE_FEE: begin
                  if (!ext_eng) begin
                     r_next.state = r_reg.ref_valid ?
                                    S_FEE_UNL : S_SCM;
                  end
               end
            endcase
            if (r_next.state == S_FEI_UNL &&
                r_next.good_cnt == LOCK_WINDOWS) begin
               r_next.state = S_FEI_LCK;
            end
            if (r_next.state == S_FEE_UNL &&
                r_next.good_cnt == LOCK_WINDOWS) begin
               r_next.state = S_FEE_LCK;
            end
            if (lock_lost && r_reg.state == S_FEI_LCK) begin
               r_next.state = S_FEI_UNL;
            end
            if (lock_lost && r_reg.state == S_FEE_LCK) begin
               r_next.state = S_FEE_UNL;
            end
            if (stop_request) begin
               r_next.state = S_OFF;
            end
         end
         default: r_next.state = S_SCM;
      endcase

      r_next.locked = (r_next.state == S_FEI_LCK) ||
                      (r_next.state == S_FEE_LCK);
      r_next.osc_en = r_next.cfg_done && !r_next.ext_blocked;

      // Clock select and post-loop divider
      src_lvl = (r_reg.state == S_FBE) ? r_reg.ref_lvl : dco_lvl;
      div_taps = {r_reg.div_cnt, src_lvl};
      if (r_reg.state != S_OFF) begin
         r_next.src_prev = src_lvl;
         if (src_lvl && !r_reg.src_prev) begin
            r_next.div_cnt = r_reg.div_cnt + 7'h01;
         end
         r_next.gen_out = div_taps[r_reg.post_div];
      end
      // Off mode leaves gen_out at its last level

      r_next.ffe = ext_mode && ext_rise;

      // Sticky loss indications; a new event beats the clear
      if (lock_lost) begin
         r_next.lost_lock = 1'b1;
      end else if (loss_clear) begin
         r_next.lost_lock = 1'b0;
      end
      if ((lock_lost || clk_lost) && loss_select) begin
         r_next.loss_rst = 1'b1;
      end else if (loss_clear) begin
         r_next.loss_rst = 1'b0;
      end
      if ((lock_lost || clk_lost) && !loss_select) begin
         r_next.loss_irq = 1'b1;
      end else if (loss_clear) begin
         r_next.loss_irq = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         r_reg           <= '0;
         r_reg.state     <= S_SCM;
         r_reg.mode      <= MODE_SCM;
         r_reg.trim      <= TRIM_RESET;
         r_reg.dco_w     <= DCO_RESET_W;
         r_reg.int_cnt   <= 9'h001;
      end else begin
         r_reg <= r_next;
      end
   end

   assign gen_clock_out            = r_reg.gen_out;
   assign loop_multiplied_clock    = r_reg.dco_acc[15];
   assign external_reference_clock = r_reg.ref_lvl;
   assign debug_local_clock        = r_reg.dbg_out;
   assign rti_clock                = r_reg.rti_out;
   assign fixed_freq_enable        = r_reg.ffe;
   assign loss_reset_req           = r_reg.loss_rst;
   assign loss_irq                 = r_reg.loss_irq;
   assign internal_ref_trim        = r_reg.trim;

   // Oscillator pins are only claimed when external modes stay open
   assign osc_ctl.osc_enable = r_reg.osc_en;
   assign osc_ctl.high_gain_select      = r_reg.high_gain;
   assign osc_ctl.range_high            = r_reg.range_high;
   assign osc_ctl.reference_type_select = r_reg.ref_osc;

   assign status.locked      = r_reg.locked;
   assign status.lost_lock   = r_reg.lost_lock;
   assign status.ref_valid   = r_reg.ref_valid;
   assign status.ext_blocked = r_reg.ext_blocked;
   assign status.state       = r_reg.state;

endmodule : fcg_clock_gen
`default_nettype wire

// ---- tb/fcg_ref_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module fcg_ref_source #(
   parameter int HALF_NS = 500
) (
   input  wire logic run,
   output logic      ext_ref_pin
);
   // A removed source leaves the pin resting low
   initial ext_ref_pin = 1'b0;
   always begin
      #(HALF_NS);
      ext_ref_pin = run ? ~ext_ref_pin : 1'b0;
   end
endmodule : fcg_ref_source
`default_nettype wire

// ---- tb/fcg_clock_gen_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module fcg_clock_gen_assertions
   import fcg_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        cfg_write,
   input wire fcg_cfg_t    cfg_data,
   input wire logic        trim_write,
   input wire logic [7:0]  trim_data,
   input wire logic        stop_request,
   input wire logic        loss_select,
   input wire logic        loss_clear,
   input wire logic        gen_clock_out,
   input wire logic        debug_local_clock,
   input wire logic        fixed_freq_enable,
   input wire logic        loss_reset_req,
   input wire logic        loss_irq,
   input wire logic [7:0]  internal_ref_trim,
   input wire fcg_osc_t    osc_ctl,
   input wire fcg_status_t status
);
   logic ext_st;
   logic cfg_seen_reg;
   assign ext_st = status.state inside {S_FBE, S_FEE_UNL, S_FEE_LCK};
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_seen_reg <= 1'b0;
      end else if (cfg_write) begin
         cfg_seen_reg <= 1'b1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   reset_mode_a: assert property (
      $fell(reset) |-> status.state == S_SCM) else $error("not self-clocked");
   stop_enter_a: assert property (
      stop_request |=> status.state == S_OFF) else $error("off not entered");
   off_frozen_a: assert property (
      status.state == S_OFF ##1 status.state == S_OFF |-> $stable(gen_clock_out))
      else $error("clock moved in off mode");
   fei_decode_a: assert property (
      (cfg_write && cfg_data.clock_mode_select == MODE_FEI && !stop_request)
      ##1 (!stop_request && !cfg_write) |=>
      status.state inside {S_FEI_UNL, S_FEI_LCK}) else $error("bad decode");
   ext_needs_ref_a: assert property (
      $rose(ext_st) |-> $past(status.ref_valid)) else $error("dead source");
   blocked_no_ext_a: assert property (
      status.ext_blocked |-> !ext_st) else $error("blocked mode entered");
   ffe_pulse_a: assert property (
      fixed_freq_enable |-> ($past(ext_st) || ext_st) ##1 !fixed_freq_enable)
      else $error("bad fixed enable");
   lost_sticky_a: assert property (
      status.lost_lock && !loss_clear |=> status.lost_lock)
      else $error("lost lock dropped");
   irq_route_a: assert property (
      $rose(loss_irq) |-> !$past(loss_select)) else $error("irq misrouted");
   reset_route_a: assert property (
      $rose(loss_reset_req) |-> $past(loss_select)) else $error("reset misrouted");
   trim_load_a: assert property (
      trim_write |=> internal_ref_trim == $past(trim_data))
      else $error("trim not loaded");
   dbg_wave_a: assert property (
      $rose(debug_local_clock) |=> debug_local_clock [*2] ##1
      !debug_local_clock [*2] ##1 debug_local_clock) else $error("bad debug clock");
   write_once_a: assert property (
      cfg_seen_reg |=> $stable(osc_ctl[2:0])) else $error("osc setting changed");
   cover property ($rose(status.locked));
   cover property (status.state == S_FBE);
   cover property ($rose(loss_reset_req));
   cover property (status.state == S_OFF);
endmodule : fcg_clock_gen_assertions
bind fcg_clock_gen fcg_clock_gen_assertions u_chk (.clk(clk), .reset(reset),
   .cfg_write(cfg_write), .cfg_data(cfg_data), .trim_write(trim_write),
   .trim_data(trim_data), .stop_request(stop_request),
   .loss_select(loss_select), .loss_clear(loss_clear),
   .gen_clock_out(gen_clock_out), .debug_local_clock(debug_local_clock),
   .fixed_freq_enable(fixed_freq_enable), .loss_reset_req(loss_reset_req),
   .loss_irq(loss_irq), .internal_ref_trim(internal_ref_trim),
   .osc_ctl(osc_ctl), .status(status));
`default_nettype wire

// ---- tb/fcg_clock_gen_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module fcg_clock_gen_tb
   import fcg_pkg::*;
;
   typedef struct {int due; int code; logic [7:0] val;} fcg_note_t;
   fcg_note_t   q[$];
   fcg_note_t   nt;
   string       nm[13] = '{"state", "trim", "osc", "blocked", "ref_valid",
                          "lock", "loss", "dco", "gen", "eref", "dbg",
                          "rti", "ffe"};
   int          cyc = 0;
   int          k;
   int          n_tests = 0;
   int          miscompares = 0;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        cfg_write = 1'b0;
   fcg_cfg_t    cfg_data = '0;
   logic [2:0]  mult_select = 3'h0;
   logic [2:0]  post_div_select = 3'h0;
   logic        trim_write = 1'b0;
   logic [7:0]  trim_data = 8'h00;
   logic        stop_request = 1'b0;
   logic        loss_select = 1'b0;
   logic        loss_clear = 1'b0;
   logic        ref_run = 1'b0;
   wire logic   ext_ref_pin;
   logic        dco;
   logic        gen;
   logic        eref;
   logic        dbg;
   logic        rti;
   logic        ffe;
   logic        loss_reset_req;
   logic        loss_irq;
   logic [7:0]  internal_ref_trim;
   fcg_osc_t    osc_ctl;
   fcg_status_t status;

   always #12.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   fcg_ref_source #(.HALF_NS(487)) u_ref (.run(ref_run),
      .ext_ref_pin(ext_ref_pin));

   fcg_clock_gen u_dut (.clk(clk), .reset(reset), .cfg_write(cfg_write),
      .cfg_data(cfg_data), .mult_select(mult_select),
      .post_div_select(post_div_select), .trim_write(trim_write),
      .trim_data(trim_data), .stop_request(stop_request),
      .loss_select(loss_select), .loss_clear(loss_clear),
      .ext_ref_pin(ext_ref_pin), .gen_clock_out(gen),
      .loop_multiplied_clock(dco), .external_reference_clock(eref),
      .debug_local_clock(dbg), .rti_clock(rti), .fixed_freq_enable(ffe),
      .loss_reset_req(loss_reset_req), .loss_irq(loss_irq),
      .internal_ref_trim(internal_ref_trim), .osc_ctl(osc_ctl),
      .status(status));

   function automatic logic [7:0] obs(input int c);
      case (c)
         0: obs = {1'b0, status.state};
         1: obs = internal_ref_trim;
         2: obs = {5'h00, osc_ctl[2:0]};
         3: obs = {7'h00, status.ext_blocked};
         4: obs = {7'h00, status.ref_valid};
         5: obs = {6'h00, status.lost_lock, status.locked};
         6: obs = {6'h00, loss_reset_req, loss_irq};
         7: obs = {7'h00, dco};
         8: obs = {7'h00, gen};
         9: obs = {7'h00, eref};
         10: obs = {7'h00, dbg};
         11: obs = {7'h00, rti};
         default: obs = {7'h00, ffe};
      endcase
   endfunction : obs

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict

   task automatic note(input int c, input logic [7:0] v, input int d);
      q.push_back('{cyc + d, c, v});
   endtask : note

   task automatic wait_for(input int c, input logic [7:0] v, input int n);
      int i;
      for (i = 0; i < n; i++) begin
         @(negedge clk);
         if (obs(c) === v) break;
      end
      note(c, v, 0);
      if (i == n) begin
         $display("unexpected %s: expected %h, seen %h", nm[c], v, obs(c));
         miscompares++;
         give_verdict();
      end
   endtask : wait_for

   task automatic cfg(input logic [4:0] v, input logic [2:0] o,
                      input fcg_state_t s, input logic b);
      @(posedge clk);
      cfg_write <= 1'b1;
      cfg_data  <= v;
      @(negedge clk);
      note(2, {5'h00, o}, 1);
      note(3, {7'h00, b}, 1);
      note(0, {1'b0, s}, 2);
      @(posedge clk);
      cfg_write <= 1'b0;
   endtask : cfg

   task automatic do_reset();
      @(posedge clk);
      reset <= 1'b1;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
   endtask : do_reset

   // Results are compared once their due cycle has settled
   always @(negedge clk) begin
      #2;
      while (q.size() > 0 && q[0].due <= cyc) begin
         nt = q.pop_front();
         n_tests++;
         if (obs(nt.code) !== nt.val) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", nm[nt.code],
                     nt.val, obs(nt.code));
         end
      end
   end

   initial begin
      void'($urandom(52));
      do_reset();
      @(negedge clk);
      note(0, {1'b0, S_SCM}, 0);
      note(1, 8'h80, 0);
      wait_for(10, 8'h01, 10);
      $display("test reset defaults done");
      for (k = 0; k < 3; k++) begin
         @(posedge clk);
         trim_write <= 1'b1;
         trim_data  <= (k == 2) ? 8'hff : 8'($urandom);
         @(negedge clk);
         note(1, trim_data, 1);
      end
      @(posedge clk);
      trim_write      <= 1'b0;
      post_div_select <= 3'($urandom);
      wait_for(8, 8'h01, 3000);
      wait_for(8, 8'h00, 3000);
      $display("test trim done");
      cfg(5'b11101, 3'b111, S_FEI_UNL, 1'b1);
      cfg(5'b00011, 3'b111, S_FEI_UNL, 1'b1);
      wait_for(5, 8'h01, 40000);
      note(0, {1'b0, S_FEI_LCK}, 0);
      $display("test internal lock done");
      @(posedge clk);
      stop_request <= 1'b1;
      @(negedge clk);
      note(0, {1'b0, S_OFF}, 1);
      repeat (20) @(posedge clk);
      stop_request <= 1'b0;
      wait_for(5, 8'h01, 4000);
      $display("test stop and relock done");
      do_reset();
      loss_select <= 1'b1;
      cfg(5'b01010, 3'b010, S_SCM, 1'b0);
      @(posedge clk);
      ref_run <= 1'b1;
      wait_for(4, 8'h01, 600);
      wait_for(9, 8'h01, 100);
      cfg(5'b00010, 3'b010, S_FBE, 1'b0);
      wait_for(12, 8'h01, 100);
      @(posedge clk);
      mult_select <= 3'(1 + $urandom % 3);
      cfg(5'b00011, 3'b010, S_FEE_UNL, 1'b0);
      wait_for(5, 8'h01, 20000);
      $display("test external modes done");
      @(posedge clk);
      mult_select <= 3'h7;
      loss_select <= 1'b0;
      wait_for(5, 8'h02, 200);
      wait_for(6, 8'h01, 5);
      $display("test lock loss done");
      @(posedge clk);
      loss_select <= 1'b1;
      ref_run     <= 1'b0;
      wait_for(4, 8'h00, 4200);
      wait_for(6, 8'h03, 20);
      wait_for(7, 8'h01, 300);
      wait_for(7, 8'h00, 300);
      @(posedge clk);
      loss_clear <= 1'b1;
      @(negedge clk);
      note(6, 8'h00, 1);
      @(posedge clk);
      loss_clear <= 1'b0;
      repeat (4) @(posedge clk);
      $display("test reference loss done");
      wait_for(11, 8'h01, 25000);
      $display("test rti source done");
      give_verdict();
   end
endmodule : fcg_clock_gen_tb
`default_nettype wire
